// ==== rtl/cmd_decode_pkg.sv ====
package cmd_decode_pkg;

  // Header byte: upper nibble is the group, lower nibble the data count.
  localparam logic [3:0] HDR_GROUP       = 4'h2;
  localparam int         HDR_LEN_LSB     = 0;
  localparam int         HDR_GROUP_LSB   = 4;
  localparam logic [3:0] LEN_QUERY       = 4'h1;
  localparam logic [3:0] LEN_PROG_READ   = 4'h2;
  localparam logic [3:0] LEN_PROG_WRITE  = 4'h3;

  // Identifier bytes of the write commands.
  localparam logic [7:0] ID_WR_REGISTER  = 8'h12;
  localparam logic [7:0] ID_WR_CV_LEGACY = 8'h16;
  localparam logic [7:0] ID_WR_PAGE      = 8'h17;
  localparam logic [7:0] ID_WR_BANK0     = 8'h1C;
  localparam logic [7:0] ID_WR_BANK1     = 8'h1D;
  localparam logic [7:0] ID_WR_BANK2     = 8'h1E;
  localparam logic [7:0] ID_WR_BANK3     = 8'h1F;

  // Identifier bytes of the programming reads, which only open programming mode here.
  localparam logic [7:0] ID_RD_REGISTER  = 8'h11;
  localparam logic [7:0] ID_RD_PAGE      = 8'h14;
  localparam logic [7:0] ID_RD_CV_LEGACY = 8'h15;
  localparam logic [7:0] ID_RD_BANK0     = 8'h18;
  localparam logic [7:0] ID_RD_BANK3     = 8'h1B;

  // Identifier bytes of the one-byte queries.
  localparam logic [7:0] ID_Q_PROG_RESULT = 8'h10;
  localparam logic [7:0] ID_Q_VERSION     = 8'h21;
  localparam logic [7:0] ID_Q_EXT_VERSION = 8'h23;
  localparam logic [7:0] ID_Q_STATUS      = 8'h24;

  // Numbering of configuration variables.
  localparam logic [10:0] CV_TOP_ALIAS    = 11'h400;
  localparam logic [10:0] CV_LEGACY_ZERO  = 11'h100;
  localparam logic [10:0] CV_BANK1_BASE   = 11'h100;
  localparam logic [10:0] CV_BANK2_BASE   = 11'h200;
  localparam logic [10:0] CV_BANK3_BASE   = 11'h300;
  localparam logic [3:0]  REG_FIRST       = 4'h1;
  localparam logic [3:0]  REG_LAST        = 4'h8;
  localparam logic [3:0]  PAGE_REG_COUNT  = 4'h4;
  localparam logic [3:0]  PAGE_REG_SELECT = 4'h6;

  // Buffer shape and reset values.
  localparam int          FIFO_WIDTH      = 8;
  localparam int          FIFO_DEPTH      = 8;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;

  // Kinds of write passed to the track side.
  typedef enum logic [1:0] {
    WR_REGISTER,
    WR_CV,
    WR_PAGE
  } write_kind_t;

  // Queries answered by the station.
  typedef enum logic [1:0] {
    Q_VERSION,
    Q_EXT_VERSION,
    Q_STATUS,
    Q_PROG_RESULT
  } query_kind_t;

endpackage : cmd_decode_pkg

// ==== rtl/byte_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Filling side.
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Draining side.
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written without reset; only the pointers and the count need a defined value.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : byte_fifo

`default_nettype wire

// ==== rtl/prog_write_and_query_decoder.sv ====
// What this block does, and what the document asks of its partner (R08, R09)
// R01: Register write 0x12 enters programming, registers 1-8.
// R02: Legacy write 0x16, zero addresses variable 1024 with NEW_NUMBERING, else 256.
// R03: Write 0x1C targets address, zero means 1024.
// R04: Write 0x1D targets 256 plus address.
// R05: Write 0x1E targets 512 plus address.
// R06: Write 0x1F targets 768 plus address.
// R07: Page write 0x17 becomes page and register.
// R08: Partner reads before register writes, recommended.
// R09: Partner checks page support, verifies by reading.
// R10: Message 21 21 00 requests software version.
// R11: Message 21 23 02 requests extended version.
// R12: Message 21 24 05 requests station status.
// R13: Programming read broadcasts notice, then locks device.
// R14: Message 21 10 31 returns last read result.
// R15: Check byte is XOR; mismatches are discarded.
// R16: Header low nibble counts data bytes.
// R17: Unknown identifiers ignored, programming state unchanged.
`timescale 1ns/10ps
`default_nettype none

module prog_write_and_query_decoder (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Incoming byte stream with the sender's bus address.
  input  wire logic [7:0]  RX_BYTE,
  input  wire logic [4:0]  RX_SOURCE,
  input  wire logic        RX_VALID,
  output logic             RX_READY,
  // Programming write request to the track side.
  output logic             WR_VALID,
  input  wire logic        WR_READY,
  output cmd_decode_pkg::write_kind_t WR_KIND,
  output logic [10:0]      WR_CV,
  output logic [3:0]       WR_REG,
  output logic [7:0]       WR_PAGE,
  output logic [7:0]       WR_DATA,
  // Query request to the answer side.
  output logic             Q_VALID,
  output cmd_decode_pkg::query_kind_t Q_KIND,
  output logic [4:0]       Q_DEST,
  // Programming mode state.
  output logic             PROG_MODE,
  output logic [4:0]       PROG_OWNER,
  output logic             PROG_NOTICE,
  // Station revision selects the meaning of legacy address zero.
  input  wire logic        NEW_NUMBERING,
  // Diagnostic pulse for a discarded message.
  output logic             BAD_MSG
);

  typedef enum logic [1:0] {S_HEADER, S_BODY, S_CHECK} parse_t;

  parse_t      state;
  logic [7:0]  fifo_byte;
  logic [4:0]  fifo_src;
  logic        fifo_valid;
  logic        fifo_take;
  logic [3:0]  remain;
  logic [3:0]  idx;
  logic [3:0]  len;
  logic [7:0]  running_xor;
  logic [7:0]  body [4];
  logic [4:0]  src;
  logic        blocked;

  // Computes the page register of a page-mode write from a one-based variable.
  function automatic logic [3:0] page_register(input logic [8:0] cv);
    logic [8:0] zb;
    zb = cv - 9'h001;
    return 4'(zb[1:0]) + cmd_decode_pkg::REG_FIRST;
  endfunction : page_register

  // Each byte carries its sender, so a header queued behind a held write keeps its owner.
  byte_fifo #(
    .WIDTH (cmd_decode_pkg::FIFO_WIDTH + 5),
    .DEPTH (cmd_decode_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_data   ({RX_SOURCE, RX_BYTE}),
    .in_valid  (RX_VALID),
    .in_ready  (RX_READY),
    .out_data  ({fifo_src, fifo_byte}),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  // A pending write stalls parsing, which fills the buffer and pushes back.
  assign blocked   = WR_VALID && !WR_READY;
  assign fifo_take = fifo_valid && !blocked;

  // R16 length framing
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= S_HEADER;
      remain <= '0;
      idx <= '0;
      len <= '0;
      src <= '0;
    end else if (fifo_take) begin
      case (state)
        S_HEADER: begin
          len    <= fifo_byte[cmd_decode_pkg::HDR_LEN_LSB +: 4];
          remain <= fifo_byte[cmd_decode_pkg::HDR_LEN_LSB +: 4];
          idx    <= '0;
          src    <= fifo_src;
          state  <= (fifo_byte[3:0] == 4'h0) ? S_CHECK : S_BODY;
        end
        S_BODY: begin
          idx    <= idx + 4'h1;
          remain <= remain - 4'h1;
          if (remain == 4'h1) begin
            state <= S_CHECK;
          end
        end
        default: begin
          state <= S_HEADER;
        end
      endcase
    end
  end

  // Keeps the header and first three data bytes; longer messages are only framed.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      running_xor <= cmd_decode_pkg::BYTE_RESET;
      for (int i = 0; i < 4; i++) begin
        body[i] <= cmd_decode_pkg::BYTE_RESET;
      end
    end else if (fifo_take) begin
      if (state == S_HEADER) begin
        running_xor <= fifo_byte;
        body[0]     <= fifo_byte;
      end else if (state == S_BODY) begin
        running_xor <= running_xor ^ fifo_byte;
        if (idx < 4'h3) begin
          body[2'(idx + 4'h1)] <= fifo_byte;
        end
      end
    end
  end

  logic       msg_end;
  logic       msg_good;
  logic [3:0] grp;
  logic [7:0] ident;
  logic [7:0] addr;
  logic       from_owner;
  assign msg_end    = fifo_take && (state == S_CHECK);
  // R15 check byte
  assign msg_good   = msg_end && (fifo_byte == running_xor);
  assign grp        = body[0][cmd_decode_pkg::HDR_GROUP_LSB +: 4];
  assign ident      = body[1];
  assign addr       = body[2];
  // R13 owner lockout
  assign from_owner = !PROG_MODE || (src == PROG_OWNER);

  logic is_write;
  logic is_read;
  assign is_write = msg_good && from_owner && grp == cmd_decode_pkg::HDR_GROUP
                    && len == cmd_decode_pkg::LEN_PROG_WRITE;
  assign is_read  = msg_good && from_owner && grp == cmd_decode_pkg::HDR_GROUP
                    && len == cmd_decode_pkg::LEN_PROG_READ
                    && ident >= cmd_decode_pkg::ID_RD_REGISTER
                    && ident <= cmd_decode_pkg::ID_RD_BANK3
                    && ident != 8'h12 && ident != 8'h13 && ident != 8'h16 && ident != 8'h17;

  // Write decode; an unmatched identifier leaves every output alone.
  logic        wr_hit;
  cmd_decode_pkg::write_kind_t next_kind;
  logic [10:0] next_cv;
  always_comb begin
    wr_hit    = 1'b0;
    next_kind = cmd_decode_pkg::WR_CV;
    next_cv   = {3'h0, addr};
    if (!is_write) begin
      wr_hit = 1'b0;
    // R01 register write
    end else if (ident == cmd_decode_pkg::ID_WR_REGISTER) begin
      wr_hit    = addr[3:0] >= cmd_decode_pkg::REG_FIRST && addr[3:0] <= cmd_decode_pkg::REG_LAST
                  && addr[7:4] == 4'h0;
      next_kind = cmd_decode_pkg::WR_REGISTER;
    // R02 legacy numbering
    end else if (ident == cmd_decode_pkg::ID_WR_CV_LEGACY) begin
      wr_hit = 1'b1;
      if (addr == 8'h00) begin
        next_cv = NEW_NUMBERING ? cmd_decode_pkg::CV_TOP_ALIAS : cmd_decode_pkg::CV_LEGACY_ZERO;
      end
    // R03 bank zero
    end else if (ident == cmd_decode_pkg::ID_WR_BANK0) begin
      wr_hit = 1'b1;
      if (addr == 8'h00) begin
        next_cv = cmd_decode_pkg::CV_TOP_ALIAS;
      end
    // R04 bank one
    end else if (ident == cmd_decode_pkg::ID_WR_BANK1) begin
      wr_hit  = 1'b1;
      next_cv = cmd_decode_pkg::CV_BANK1_BASE + {3'h0, addr};
    // R05 bank two
    end else if (ident == cmd_decode_pkg::ID_WR_BANK2) begin
      wr_hit  = 1'b1;
      next_cv = cmd_decode_pkg::CV_BANK2_BASE + {3'h0, addr};
    // R06 bank three
    end else if (ident == cmd_decode_pkg::ID_WR_BANK3) begin
      wr_hit  = 1'b1;
      next_cv = cmd_decode_pkg::CV_BANK3_BASE + {3'h0, addr};
    // R07 page mode
    end else if (ident == cmd_decode_pkg::ID_WR_PAGE) begin
      wr_hit    = 1'b1;
      next_kind = cmd_decode_pkg::WR_PAGE;
      if (addr == 8'h00) begin
        next_cv = cmd_decode_pkg::CV_LEGACY_ZERO;
      end
    end
  end

  // R17 ignore unknown
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      WR_VALID <= 1'b0;
      WR_KIND  <= cmd_decode_pkg::WR_REGISTER;
      WR_CV    <= '0;
      WR_REG   <= '0;
      WR_PAGE  <= '0;
      WR_DATA  <= '0;
    end else if (wr_hit) begin
      WR_VALID <= 1'b1;
      WR_KIND  <= next_kind;
      WR_CV    <= next_cv;
      WR_DATA  <= body[3];
      if (next_kind == cmd_decode_pkg::WR_PAGE) begin
        WR_REG  <= page_register(next_cv[8:0]);
        WR_PAGE <= 8'((next_cv[8:0] - 9'h001) >> 2) + 8'h01;
      end else begin
        WR_REG  <= addr[3:0];
        WR_PAGE <= '0;
      end
    end else if (WR_READY) begin
      WR_VALID <= 1'b0;
    end
  end

  // R13 programming mode
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PROG_MODE   <= 1'b0;
      PROG_OWNER  <= '0;
      PROG_NOTICE <= 1'b0;
    end else begin
      PROG_NOTICE <= is_read && !PROG_MODE;
      if (is_read || wr_hit) begin
        PROG_MODE  <= 1'b1;
        PROG_OWNER <= src;
      end
    end
  end

  // Query decode; the query is a pulse and is never held back.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      Q_VALID <= 1'b0;
      Q_KIND  <= cmd_decode_pkg::Q_VERSION;
      Q_DEST  <= '0;
      BAD_MSG <= 1'b0;
    end else begin
      BAD_MSG <= msg_end && !msg_good;
      Q_VALID <= 1'b0;
      if (msg_good && from_owner && body[0] == {cmd_decode_pkg::HDR_GROUP, cmd_decode_pkg::LEN_QUERY}) begin
        Q_DEST <= src;
        // R10 version query
        if (ident == cmd_decode_pkg::ID_Q_VERSION) begin
          Q_VALID <= 1'b1;
          Q_KIND  <= cmd_decode_pkg::Q_VERSION;
        // R11 extended version
        end else if (ident == cmd_decode_pkg::ID_Q_EXT_VERSION) begin
          Q_VALID <= 1'b1;
          Q_KIND  <= cmd_decode_pkg::Q_EXT_VERSION;
        // R12 status query
        end else if (ident == cmd_decode_pkg::ID_Q_STATUS) begin
          Q_VALID <= 1'b1;
          Q_KIND  <= cmd_decode_pkg::Q_STATUS;
        // R14 read result
        end else if (ident == cmd_decode_pkg::ID_Q_PROG_RESULT) begin
          Q_VALID <= 1'b1;
          Q_KIND  <= cmd_decode_pkg::Q_PROG_RESULT;
        end
      end
    end
  end

endmodule : prog_write_and_query_decoder

`default_nettype wire

// ==== testbench/prog_write_and_query_decoder_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none

module prog_write_and_query_decoder_asserts (
  // Clock and reset.
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  // Decoder outputs and the track-side handshake.
  input  wire logic                        RX_READY,
  input  wire logic                        WR_VALID,
  input  wire logic                        WR_READY,
  input  wire cmd_decode_pkg::write_kind_t WR_KIND,
  input  wire logic [10:0]                 WR_CV,
  input  wire logic [3:0]                  WR_REG,
  input  wire logic [7:0]                  WR_PAGE,
  input  wire logic [7:0]                  WR_DATA,
  input  wire logic                        Q_VALID,
  input  wire logic                        PROG_MODE,
  input  wire logic [4:0]                  PROG_OWNER,
  input  wire logic                        PROG_NOTICE,
  input  wire logic                        BAD_MSG
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_write_held_stall: assert property (WR_VALID && !WR_READY |=> WR_VALID
    && $stable({WR_KIND, WR_CV, WR_REG, WR_PAGE, WR_DATA})) else $error("write changed in stall");
  a_write_one_take: assert property (WR_VALID && WR_READY |=> !WR_VALID)
    else $error("write stood after take");
  a_write_sets_mode: assert property ($rose(WR_VALID) |-> ##[0:1] PROG_MODE)
    else $error("write without programming mode");
  a_reg_in_range: assert property (WR_VALID && WR_KIND == cmd_decode_pkg::WR_REGISTER
    |-> WR_REG inside {[4'h1:4'h8]}) else $error("register index out of range");
  a_cv_in_range: assert property (WR_VALID && WR_KIND == cmd_decode_pkg::WR_CV
    |-> WR_CV inside {[11'h001:11'h400]}) else $error("variable number out of range");
  a_page_map_range: assert property (WR_VALID && WR_KIND == cmd_decode_pkg::WR_PAGE
    |-> WR_REG inside {[4'h1:4'h4]} && WR_PAGE inside {[8'h01:8'h40]}) else $error("bad page");
  a_query_one_cycle: assert property (Q_VALID |=> !Q_VALID)
    else $error("query pulse too long");
  a_notice_then_mode: assert property (PROG_NOTICE |=> !PROG_NOTICE && PROG_MODE)
    else $error("notice pulse wrong");
  a_owner_kept: assert property (PROG_MODE |=> PROG_MODE && $stable(PROG_OWNER))
    else $error("programming owner changed");
  a_bad_is_quiet: assert property (BAD_MSG |-> !Q_VALID && !PROG_NOTICE && !$rose(WR_VALID))
    else $error("discarded message acted");

  // The main scenarios the bench should reach.
  c_write_stall: cover property (WR_VALID && !WR_READY);
  c_notice: cover property (PROG_NOTICE);
  c_bad: cover property (BAD_MSG);
  c_full: cover property (!RX_READY);
endmodule : prog_write_and_query_decoder_asserts

bind prog_write_and_query_decoder prog_write_and_query_decoder_asserts u_asserts (
  .CLK(CLK), .RST_N(RST_N), .RX_READY(RX_READY), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
  .WR_KIND(WR_KIND), .WR_CV(WR_CV), .WR_REG(WR_REG), .WR_PAGE(WR_PAGE), .WR_DATA(WR_DATA),
  .Q_VALID(Q_VALID), .PROG_MODE(PROG_MODE), .PROG_OWNER(PROG_OWNER),
  .PROG_NOTICE(PROG_NOTICE), .BAD_MSG(BAD_MSG));

`default_nettype wire

// ==== testbench/msg_sender.sv ====
`timescale 1ns/10ps
`default_nettype none

module msg_sender (
  // Clock.
  input  wire logic  clk,
  // Byte stream towards the station.
  output logic [7:0] rx_byte,
  output logic [4:0] rx_source,
  output logic       rx_valid,
  input  wire logic  rx_ready
);
  // Idle bus at time zero.
  initial begin
    rx_byte = 8'h00;
    rx_source = 5'h00;
    rx_valid = 1'b0;
  end

  // Offers a message a byte per cycle; holds each byte until the station can take it.
  task automatic send(input logic [4:0] src, input logic [7:0] body[$], input logic spoil);
    logic [7:0] cs;
    body[0] = body[0] | 8'(body.size() - 1);
    cs = 8'h00;
    foreach (body[i]) cs ^= body[i];
    body.push_back(cs ^ {8{spoil}});
    foreach (body[i]) begin
      @(negedge clk);
      rx_source = src;
      rx_byte = body[i];
      rx_valid = 1'b1;
      while (!rx_ready) @(negedge clk);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    // A released line must not keep showing the last byte.
    rx_byte = ~rx_byte;
  endtask : send
endmodule : msg_sender

`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam logic [1:0]  KR = cmd_decode_pkg::WR_REGISTER;
  localparam logic [1:0]  KC = cmd_decode_pkg::WR_CV;
  localparam logic [1:0]  KP = cmd_decode_pkg::WR_PAGE;
  localparam logic [1:0]  KX = 2'h3;
  localparam logic [32:0] MR = 33'h1800F00FF;
  localparam logic [32:0] MC = 33'h1FFF000FF;
  localparam logic [32:0] MP = 33'h1800FFFFF;
  logic                        CLK, RST_N, RX_VALID, RX_READY, WR_VALID, WR_READY, Q_VALID;
  logic                        PROG_MODE, PROG_NOTICE, NEW_NUMBERING, BAD_MSG;
  logic [7:0]                  RX_BYTE, WR_PAGE, WR_DATA;
  logic [4:0]                  RX_SOURCE, Q_DEST, PROG_OWNER;
  logic [10:0]                 WR_CV;
  logic [3:0]                  WR_REG;
  cmd_decode_pkg::write_kind_t WR_KIND;
  cmd_decode_pkg::query_kind_t Q_KIND;
  logic [32:0]                 wr_seen[$];
  logic [6:0]                  q_seen[$];
  int                          failures, comparisons, notices, bads;

  // Free-running 50 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  prog_write_and_query_decoder u_prog_write_and_query_decoder (.CLK(CLK), .RST_N(RST_N),
    .RX_BYTE(RX_BYTE), .RX_SOURCE(RX_SOURCE), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
    .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_KIND(WR_KIND), .WR_CV(WR_CV), .WR_REG(WR_REG),
    .WR_PAGE(WR_PAGE), .WR_DATA(WR_DATA), .Q_VALID(Q_VALID), .Q_KIND(Q_KIND), .Q_DEST(Q_DEST),
    .PROG_MODE(PROG_MODE), .PROG_OWNER(PROG_OWNER), .PROG_NOTICE(PROG_NOTICE),
    .NEW_NUMBERING(NEW_NUMBERING), .BAD_MSG(BAD_MSG));
  msg_sender u_msg_sender (.clk(CLK), .rx_byte(RX_BYTE), .rx_source(RX_SOURCE),
    .rx_valid(RX_VALID), .rx_ready(RX_READY));

  // Records every taken write, query pulse, notice and discard for later comparison.
  always @(posedge CLK) begin
    if (WR_VALID === 1'b1 && WR_READY === 1'b1) wr_seen.push_back({WR_KIND, WR_CV, WR_REG, WR_PAGE, WR_DATA});
    if (Q_VALID === 1'b1) q_seen.push_back({Q_KIND, Q_DEST});
    if (PROG_NOTICE === 1'b1) notices++;
    if (BAD_MSG === 1'b1) bads++;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Leaves room for the answer, which comes a couple of cycles after the check byte.
  task automatic drain();
    repeat (8) @(negedge CLK);
  endtask : drain

  // One owner write; kind KX means the station must drop it.
  task automatic wr(input logic [7:0] id, ad, dt, input logic [1:0] k, input logic [10:0] cv,
                    input logic [3:0] rg, input logic [7:0] pg);
    logic [32:0] m;
    m = (k == KR) ? MR : (k == KC) ? MC : MP;
    wr_seen.delete();
    u_msg_sender.send(5'h03, '{8'h20, id, ad, dt}, 1'b0);
    drain();
    check(33'(wr_seen.size()), {32'h0, k != KX});
    if (wr_seen.size() > 0)
      check(wr_seen.pop_front() & m, {k, cv, rg, pg, dt} & m);
  endtask : wr

  task automatic t_reset();
    @(negedge CLK);
    check(33'({RX_READY, WR_VALID, Q_VALID, PROG_MODE}), 33'h8);
  endtask : t_reset

  task automatic t_queries();
    logic [7:0] ids[4];
    logic [1:0] ks[4];
    ids = '{8'h21, 8'h23, 8'h24, 8'h10};
    ks = '{cmd_decode_pkg::Q_VERSION, cmd_decode_pkg::Q_EXT_VERSION, cmd_decode_pkg::Q_STATUS,
           cmd_decode_pkg::Q_PROG_RESULT};
    foreach (ids[i]) begin
      q_seen.delete();
      u_msg_sender.send(5'h07, '{8'h20, ids[i]}, 1'b0);
      drain();
      check(33'(q_seen.size()), 33'h1);
      check(33'(q_seen[0]), {26'h0, ks[i], 5'h07});
    end
  endtask : t_queries

  task automatic t_refused();
    q_seen.delete();
    u_msg_sender.send(5'h07, '{8'h20, 8'h21}, 1'b1);
    drain();
    check(33'(bads), 33'h1);
    check(33'(q_seen.size()), 33'h0);
    u_msg_sender.send(5'h07, '{8'h20, 8'h2A}, 1'b0);
    drain();
    check(33'({q_seen.size(), PROG_MODE}), 33'h0);
  endtask : t_refused

  task automatic t_prog_read();
    u_msg_sender.send(5'h03, '{8'h20, 8'h18, 8'h05}, 1'b0);
    drain();
    check(33'({PROG_MODE, PROG_OWNER}), 33'h23);
    u_msg_sender.send(5'h03, '{8'h20, 8'h11, 8'h02}, 1'b0);
    drain();
    check(33'(notices), 33'h1);
    q_seen.delete();
    wr_seen.delete();
    u_msg_sender.send(5'h04, '{8'h20, 8'h24}, 1'b0);
    u_msg_sender.send(5'h04, '{8'h20, 8'h1C, 8'h01, 8'h77}, 1'b0);
    drain();
    check(33'(q_seen.size()), 33'h0);
    check(33'(wr_seen.size()), 33'h0);
  endtask : t_prog_read

  task automatic t_writes();
    u_msg_sender.send(5'h03, '{8'h20, 8'h14, 8'h01}, 1'b0);
    NEW_NUMBERING = 1'b1;
    wr(8'h12, 8'h01, 8'h5A, KR, 11'h000, 4'h1, 8'h00);
    wr(8'h12, 8'h08, 8'hA5, KR, 11'h000, 4'h8, 8'h00);
    wr(8'h12, 8'h00, 8'h11, KX, 11'h000, 4'h0, 8'h00);
    wr(8'h12, 8'h09, 8'h11, KX, 11'h000, 4'h0, 8'h00);
    wr(8'h16, 8'h00, 8'h3C, KC, 11'h400, 4'h0, 8'h00);
    wr(8'h16, 8'h05, 8'hC3, KC, 11'h005, 4'h0, 8'h00);
    NEW_NUMBERING = 1'b0;
    wr(8'h16, 8'h00, 8'h0F, KC, 11'h100, 4'h0, 8'h00);
    wr(8'h1C, 8'h00, 8'h01, KC, 11'h400, 4'h0, 8'h00);
    wr(8'h1C, 8'hFF, 8'h02, KC, 11'h0FF, 4'h0, 8'h00);
    wr(8'h1D, 8'h00, 8'h03, KC, 11'h100, 4'h0, 8'h00);
    wr(8'h1D, 8'hFF, 8'h04, KC, 11'h1FF, 4'h0, 8'h00);
    wr(8'h1E, 8'h00, 8'h05, KC, 11'h200, 4'h0, 8'h00);
    wr(8'h1E, 8'hFF, 8'h06, KC, 11'h2FF, 4'h0, 8'h00);
    wr(8'h1F, 8'h00, 8'h07, KC, 11'h300, 4'h0, 8'h00);
    wr(8'h1F, 8'hFF, 8'h08, KC, 11'h3FF, 4'h0, 8'h00);
    wr(8'h17, 8'h00, 8'h09, KP, 11'h000, 4'h4, 8'h40);
    wr(8'h17, 8'h01, 8'h0A, KP, 11'h000, 4'h1, 8'h01);
    wr(8'h17, 8'h06, 8'h0B, KP, 11'h000, 4'h2, 8'h02);
  endtask : t_writes

  // Stalls the track side so the buffer fills, then releases it and drains all three writes.
  task automatic t_fifo_stall();
    wr_seen.delete();
    q_seen.delete();
    WR_READY = 1'b0;
    fork
      begin
        for (int i = 1; i < 4; i++)
          u_msg_sender.send(5'h03, '{8'h20, 8'h1C, 8'(i), 8'(i) * 8'h11}, 1'b0);
        // A stranger's query queues behind the owner's writes and must not take their owner.
        u_msg_sender.send(5'h04, '{8'h20, 8'h21}, 1'b0);
      end
      begin
        repeat (30) @(negedge CLK);
        check(33'({RX_READY, WR_VALID, WR_CV}), 33'h801);
        WR_READY = 1'b1;
      end
    join
    drain();
    check(33'(wr_seen.size()), 33'h3);
    check(33'(q_seen.size()), 33'h0);
    foreach (wr_seen[i]) check(wr_seen[i] & MC, {KC, 11'(i + 1), 12'h0, 8'(i + 1) * 8'h11});
  endtask : t_fifo_stall

  // Main sequence after six reset cycles.
  initial begin
    RST_N = 1'b0;
    WR_READY = 1'b1;
    NEW_NUMBERING = 1'b1;
    failures = 0;
    comparisons = 0;
    notices = 0;
    bads = 0;
    repeat (6) @(negedge CLK);
    RST_N = 1'b1;
    t_reset();
    t_queries();
    t_refused();
    t_prog_read();
    t_writes();
    t_fifo_stall();
    tally_and_finish();
  end

  // Cuts a hang short; the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge CLK);
    failures++;
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
